// file: hdl/rrtd_dma.sv
/*
 Local DMA buffer management: receive ring linking, end-of-packet header write or
 reclaim, overflow flagging, transmit fetch start, APB register slave.
 Assumes one pclk domain, byte-wide buffer memory, MAC streams synchronous to pclk.
*/
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module rrtd_dma #(
    parameter int STOP_WAIT_CYC = rrtd_pkg::STOP_WAIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rrtd_pkg::rrtd_rx_t rx_in,
    output logic rx_ready,
    output rrtd_pkg::rrtd_mem_wr_t mem_wr,
    output logic mem_rd_en,
    output logic [15:0] mem_rd_addr,
    input wire logic [7:0] mem_rd_data,
    output rrtd_pkg::rrtd_tx_t tx_out,
    input wire logic tx_ready,
    input wire logic tx_error,
    input wire logic host_wide_pin,
    output logic word_mode,
    output logic [1:0] loopback_mode,
    output logic remote_dma_en
);

    typedef struct packed {
        logic running;
        logic transmit_pending_bit;
        logic [2:0] rdma;
        logic rem_en;
        logic [7:0] ring_page_start;
        logic [7:0] pend;
        logic [7:0] bndry;
        logic [7:0] curpg;
        logic [7:0] txpg;
        logic [15:0] txcnt;
        logic [15:0] rmcnt;
        logic [7:0] istat;
        logic [7:0] txcfg;
        logic [7:0] cfg;
        rrtd_pkg::rrtd_rx_state_t rxst;
        logic [15:0] wp;
        logic [15:0] cnt;
        logic crc;
        logic aln;
        logic [7:0] nxt;
        rrtd_pkg::rrtd_mem_wr_t mem;
        logic [31:0] prdata;
        logic tx_go;
        logic word_mode;
        logic [17:0] stop_cnt;
    } rrtd_state_t;

    rrtd_state_t s;
    rrtd_state_t next_s;

    logic tx_done;
    logic wr_acc;
    logic take;
    logic first;
    logic accept;
    logic mapped;
    logic [15:0] a;
    logic [15:0] c;
    logic [7:0] pg;
    logic [7:0] set_bits;
    logic [31:0] rv;

    // Register read value and decode
    always_comb begin
        rv = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            rrtd_pkg::OFS_CMD: begin
                rv = {26'h0, s.rdma, s.transmit_pending_bit, s.running, ~s.running};
            end
            rrtd_pkg::OFS_RING_PAGE_START: begin
                rv = {24'h0, s.ring_page_start};
            end
            rrtd_pkg::OFS_PEND: begin
                rv = {24'h0, s.pend};
            end
            rrtd_pkg::OFS_BNDRY: begin
                rv = {24'h0, s.bndry};
            end
            rrtd_pkg::OFS_CURPG: begin
                rv = {24'h0, s.curpg};
            end
            rrtd_pkg::OFS_TXPG: begin
                rv = {24'h0, s.txpg};
            end
            rrtd_pkg::OFS_TXCNT: begin
                rv = {16'h0, s.txcnt};
            end
            rrtd_pkg::OFS_RMCNT: begin
                rv = {16'h0, s.rmcnt};
            end
            rrtd_pkg::OFS_ISTAT: begin
                rv = {24'h0, s.istat};
            end
            rrtd_pkg::OFS_TXCFG: begin
                rv = {24'h0, s.txcfg};
            end
            rrtd_pkg::OFS_CFG: begin
                rv = {24'h0, s.cfg};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign wr_acc = psel && penable && pwrite && mapped;
    assign first = (s.rxst == rrtd_pkg::RX_IDLE);
    assign take = rx_in.valid && ((first && s.running) || s.rxst == rrtd_pkg::RX_STORE);

    always_comb begin
        next_s = s;
        next_s.mem.we = 1'b0;
        next_s.tx_go = 1'b0;
        set_bits = 8'h00;
        accept = 1'b0;
        pg = 8'h00;
        a = first ? {s.curpg, rrtd_pkg::HDR_BYTES} : s.wp;
        c = first ? 16'h0001 : s.cnt + 16'h0001;

        // Read data is caught in the setup cycle and shown during the access phase
        if (psel && !penable && !pwrite) begin
            next_s.prdata = rv;
        end

        if (wr_acc) begin
            case (paddr)
                rrtd_pkg::OFS_CMD: begin
                    next_s.rdma = pwdata[rrtd_pkg::CMD_RDMA_LSB +: 3];
                    if (pwdata[rrtd_pkg::CMD_STOP_BIT]) begin
                        // A frame already in progress still completes
                        next_s.running = 1'b0;
                        next_s.rem_en = 1'b0;
                    end else if (pwdata[rrtd_pkg::CMD_START_BIT]) begin
                        next_s.running = 1'b1;
                        next_s.rem_en = 1'b1;
                    end
                    if (pwdata[rrtd_pkg::CMD_TXP_BIT] && !pwdata[rrtd_pkg::CMD_STOP_BIT] &&
                        (s.running || pwdata[rrtd_pkg::CMD_START_BIT]) && !s.transmit_pending_bit) begin
                        next_s.transmit_pending_bit = 1'b1;
                        next_s.tx_go = 1'b1;
                    end
                end
                rrtd_pkg::OFS_RING_PAGE_START: begin
                    next_s.ring_page_start = pwdata[7:0];
                end
                rrtd_pkg::OFS_PEND: begin
                    next_s.pend = pwdata[7:0];
                end
                rrtd_pkg::OFS_BNDRY: begin
                    next_s.bndry = pwdata[7:0];
                end
                rrtd_pkg::OFS_CURPG: begin
                    next_s.curpg = pwdata[7:0];
                end
                rrtd_pkg::OFS_TXPG: begin
                    next_s.txpg = pwdata[7:0];
                end
                rrtd_pkg::OFS_TXCNT: begin
                    next_s.txcnt = pwdata[15:0];
                end
                rrtd_pkg::OFS_RMCNT: begin
                    next_s.rmcnt = pwdata[15:0];
                end
                rrtd_pkg::OFS_ISTAT: begin
                    next_s.istat = s.istat & ~pwdata[7:0];
                end
                rrtd_pkg::OFS_TXCFG: begin
                    next_s.txcfg = pwdata[7:0];
                end
                rrtd_pkg::OFS_CFG: begin
                    next_s.cfg = pwdata[7:0];
                end
                default: begin
                    next_s.cfg = s.cfg;
                end
            endcase
        end

        // Receive path
        if (take) begin
            // Every byte, CRC included, lands right after the previous one or, past the ring end, at the ring start
            next_s.mem = '{we: 1'b1, addr: a, data: rx_in.data};
            next_s.cnt = c;
            next_s.crc = (!first && s.crc) || rx_in.crc_err;
            next_s.aln = (!first && s.aln) || rx_in.align_err;
            next_s.wp = a + 16'h0001;
            next_s.rxst = rrtd_pkg::RX_STORE;
            if (rx_in.last) begin
                accept = !((c < rrtd_pkg::MIN_FRAME) && !s.cfg[rrtd_pkg::CFG_RUNT_BIT]) &&
                         !((next_s.crc || next_s.aln) && !s.cfg[rrtd_pkg::CFG_BADCRC_BIT]);
                if (accept) begin
                    // Rest of the last page is discarded
                    next_s.nxt = rrtd_pkg::next_page(a[15:8], s.ring_page_start, s.pend);
                    next_s.rxst = rrtd_pkg::RX_HDR0;
                end else begin
                    // Current page is untouched, so all pages of this packet are reused
                    set_bits[rrtd_pkg::IS_RXE_BIT] = 1'b1;
                    next_s.rxst = rrtd_pkg::RX_IDLE;
                end
            end else if (a[7:0] == rrtd_pkg::PAGE_LAST) begin
                pg = rrtd_pkg::next_page(a[15:8], s.ring_page_start, s.pend);
                if (pg == s.bndry) begin
                    // Ring full: drop the rest, earlier packets stay intact
                    set_bits[rrtd_pkg::IS_OVW_BIT] = 1'b1;
                    next_s.rxst = rrtd_pkg::RX_DROP;
                end else begin
                    next_s.wp = {pg, 8'h00};
                end
            end
        end else begin
            case (s.rxst)
                rrtd_pkg::RX_IDLE: begin
                    if (rx_in.valid && !rx_in.last) begin
                        next_s.rxst = rrtd_pkg::RX_DROP;
                    end
                end
                rrtd_pkg::RX_DROP: begin
                    if (rx_in.valid && rx_in.last) begin
                        next_s.rxst = rrtd_pkg::RX_IDLE;
                    end
                end
                rrtd_pkg::RX_HDR0: begin
                    next_s.mem = '{we: 1'b1, addr: {s.curpg, 8'h00},
                                   data: {5'h00, s.aln, s.crc, !(s.crc || s.aln)}};
                    next_s.rxst = rrtd_pkg::RX_HDR1;
                end
                rrtd_pkg::RX_HDR1: begin
                    next_s.mem = '{we: 1'b1, addr: {s.curpg, 8'h01}, data: s.nxt};
                    next_s.rxst = rrtd_pkg::RX_HDR2;
                end
                rrtd_pkg::RX_HDR2: begin
                    next_s.mem = '{we: 1'b1, addr: {s.curpg, 8'h02}, data: s.cnt[7:0]};
                    next_s.rxst = rrtd_pkg::RX_HDR3;
                end
                rrtd_pkg::RX_HDR3: begin
                    next_s.mem = '{we: 1'b1, addr: {s.curpg, 8'h03}, data: s.cnt[15:8]};
                    next_s.curpg = s.nxt;
                    set_bits[rrtd_pkg::IS_PRX_BIT] = 1'b1;
                    next_s.rxst = rrtd_pkg::RX_IDLE;
                end
                default: begin
                    next_s.rxst = rrtd_pkg::RX_IDLE;
                end
            endcase
        end

        // Transmit completion and error
        if (tx_done && s.transmit_pending_bit) begin
            next_s.transmit_pending_bit = 1'b0;
            set_bits[rrtd_pkg::IS_PTX_BIT] = 1'b1;
        end
        if (tx_error && s.transmit_pending_bit) begin
            next_s.transmit_pending_bit = 1'b0;
            set_bits[rrtd_pkg::IS_TXE_BIT] = 1'b1;
        end

        // Reset status: set after STOP_WAIT_CYC cycles stopped with receive idle and no transmit pending, cleared while running
        if (s.running) begin
            next_s.stop_cnt = 18'h00000;
            set_bits[rrtd_pkg::IS_RST_BIT] = 1'b0;
            next_s.istat[rrtd_pkg::IS_RST_BIT] = 1'b0;
        end else if (s.rxst == rrtd_pkg::RX_IDLE && !s.transmit_pending_bit) begin
            if (s.stop_cnt == 18'(STOP_WAIT_CYC)) begin
                set_bits[rrtd_pkg::IS_RST_BIT] = 1'b1;
            end else begin
                next_s.stop_cnt = s.stop_cnt + 18'h00001;
            end
        end

        // Hardware set wins over a software clear in the same cycle
        next_s.istat = next_s.istat | set_bits;
        next_s.word_mode = s.cfg[rrtd_pkg::CFG_WTS_BIT] && host_wide_pin;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    rrtd_tx_fetch u_tx_fetch (
        .clk(pclk),
        .rst_n(presetn),
        .start(s.tx_go),
        .page(s.txpg),
        .count(s.txcnt),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data),
        .tx(tx_out),
        .tx_ready(tx_ready),
        .done(tx_done)
    );

    // Header writes own the memory port, so the MAC is held off meanwhile
    assign rx_ready = (s.rxst == rrtd_pkg::RX_IDLE) || (s.rxst == rrtd_pkg::RX_STORE) ||
                      (s.rxst == rrtd_pkg::RX_DROP);
    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign mem_wr = s.mem;
    assign word_mode = s.word_mode;
    assign loopback_mode = s.txcfg[rrtd_pkg::TXCFG_LB_LSB +: 2];
    assign remote_dma_en = s.rem_en;

endmodule // rrtd_dma

`default_nettype wire

// file: hdl/rrtd_pkg.sv
/*
 Shared constants and types for the receive ring and transmit fetch DMA.
 Assumes a byte-wide buffer memory with a 16-bit byte address, page = upper eight bits.
*/
package rrtd_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_RING_PAGE_START = 8'h04;
    localparam logic [7:0] OFS_PEND = 8'h08;
    localparam logic [7:0] OFS_BNDRY = 8'h0C;
    localparam logic [7:0] OFS_CURPG = 8'h10;
    localparam logic [7:0] OFS_TXPG = 8'h14;
    localparam logic [7:0] OFS_TXCNT = 8'h18;
    localparam logic [7:0] OFS_RMCNT = 8'h1C;
    localparam logic [7:0] OFS_ISTAT = 8'h20;
    localparam logic [7:0] OFS_TXCFG = 8'h24;
    localparam logic [7:0] OFS_CFG = 8'h28;

    // Command register fields
    localparam int CMD_STOP_BIT = 0;
    localparam int CMD_START_BIT = 1;
    localparam int CMD_TXP_BIT = 2;
    localparam int CMD_RDMA_LSB = 3;
    localparam logic [7:0] CMD_STOP_VAL = 8'h21;
    localparam logic [7:0] CMD_START_VAL = 8'h22;
    localparam logic [7:0] CMD_XMIT_VAL = 8'h26;

    // Interrupt status fields
    localparam int IS_PRX_BIT = 0;
    localparam int IS_PTX_BIT = 1;
    localparam int IS_RXE_BIT = 2;
    localparam int IS_TXE_BIT = 3;
    localparam int IS_OVW_BIT = 4;
    localparam int IS_RST_BIT = 7;

    // Configuration and transmit configuration fields
    localparam int CFG_WTS_BIT = 0;
    localparam int CFG_RUNT_BIT = 1;
    localparam int CFG_BADCRC_BIT = 2;
    localparam int TXCFG_LB_LSB = 1;

    // Ring geometry
    localparam logic [7:0] HDR_BYTES = 8'h04;
    localparam logic [7:0] PAGE_LAST = 8'hFF;
    localparam logic [15:0] MIN_FRAME = 16'h0040;

    // Settling time after a stop command
    localparam int STOP_WAIT_NS = 1500000;
    localparam int CLK_NS = 8;
    localparam int STOP_WAIT_CYC = STOP_WAIT_NS / CLK_NS;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic crc_err;
        logic align_err;
    } rrtd_rx_t;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } rrtd_mem_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } rrtd_tx_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_STORE, RX_DROP, RX_HDR0, RX_HDR1, RX_HDR2, RX_HDR3
    } rrtd_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE, TX_REQ, TX_CAP, TX_HOLD
    } rrtd_tx_state_t;

    // Page after pg, wrapping from the ring end back to the ring start
    function automatic logic [7:0] next_page(input logic [7:0] pg, input logic [7:0] ring_page_start,
                                             input logic [7:0] pend);
        logic [7:0] np;
        np = pg + 8'h01;
        next_page = (np == pend) ? ring_page_start : np;
    endfunction

endpackage

// file: hdl/rrtd_tx_fetch.sv
/*
 Transmit fetch: reads a packet byte by byte from buffer memory into the transmit FIFO.
 Assumes buffer memory returns read data the cycle after rd_en is high.
*/
`timescale 1ns/100ps
`default_nettype none

module rrtd_tx_fetch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] page,
    input wire logic [15:0] count,
    output logic rd_en,
    output logic [15:0] rd_addr,
    input wire logic [7:0] rd_data,
    output rrtd_pkg::rrtd_tx_t tx,
    input wire logic tx_ready,
    output logic done
);

    typedef struct packed {
        rrtd_pkg::rrtd_tx_state_t st;
        logic [15:0] addr;
        logic [15:0] left;
        logic rd_en;
        rrtd_pkg::rrtd_tx_t tx;
        logic done;
    } rrtd_txs_t;

    rrtd_txs_t s;
    rrtd_txs_t next_s;

    always_comb begin
        next_s = s;
        next_s.rd_en = 1'b0;
        next_s.done = 1'b0;
        case (s.st)
            rrtd_pkg::TX_IDLE: begin
                if (start) begin
                    if (count == 16'h0000) begin
                        next_s.done = 1'b1;
                    end else begin
                        next_s.addr = {page, 8'h00};
                        next_s.left = count;
                        next_s.rd_en = 1'b1;
                        next_s.st = rrtd_pkg::TX_REQ;
                    end
                end
            end
            rrtd_pkg::TX_REQ: begin
                next_s.st = rrtd_pkg::TX_CAP;
            end
            rrtd_pkg::TX_CAP: begin
                next_s.tx.valid = 1'b1;
                next_s.tx.data = rd_data;
                // The MAC appends preamble, sync and CRC after the byte marked last
                next_s.tx.last = (s.left == 16'h0001);
                next_s.st = rrtd_pkg::TX_HOLD;
            end
            rrtd_pkg::TX_HOLD: begin
                if (tx_ready) begin
                    next_s.tx.valid = 1'b0;
                    next_s.tx.last = 1'b0;
                    next_s.left = s.left - 16'h0001;
                    next_s.addr = s.addr + 16'h0001;
                    if (s.left == 16'h0001) begin
                        next_s.done = 1'b1;
                        next_s.st = rrtd_pkg::TX_IDLE;
                    end else begin
                        next_s.rd_en = 1'b1;
                        next_s.st = rrtd_pkg::TX_REQ;
                    end
                end
            end
            default: begin
                next_s.st = rrtd_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_en = s.rd_en;
    assign rd_addr = s.addr;
    assign tx = s.tx;
    assign done = s.done;

endmodule // rrtd_tx_fetch

`default_nettype wire

// file: tb/rrtd_dma_chk.sv
/*
 Port-level checker for rrtd_dma: receive header timing, byte storage, commands, transmit hold.
 Assumes it is bound into rrtd_dma and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none

module rrtd_dma_chk #(
    parameter int STOP_WAIT_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire rrtd_pkg::rrtd_rx_t rx_in,
    input wire logic rx_ready,
    input wire rrtd_pkg::rrtd_mem_wr_t mem_wr,
    input wire rrtd_pkg::rrtd_tx_t tx_out,
    input wire logic tx_ready,
    input wire logic host_wide_pin,
    input wire logic word_mode,
    input wire logic [1:0] loopback_mode,
    input wire logic remote_dma_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable && pwrite;
    sequence s_hdr;
        mem_wr.we && mem_wr.addr[7:0] == 8'h00 ##1 mem_wr.we && mem_wr.addr[7:0] == 8'h01
        ##1 mem_wr.we && mem_wr.addr[7:0] == 8'h02 ##1 mem_wr.we && mem_wr.addr[7:0] == 8'h03;
    endsequence
    property p_hdr; $fell(rx_ready) |=> s_hdr; endproperty
    property p_gap; $fell(rx_ready) |-> !rx_ready [*4] ##1 rx_ready; endproperty
    property p_store; mem_wr.we && mem_wr.addr[7:0] > 8'h03 |-> $past(rx_in.valid && rx_ready); endproperty
    property p_data; mem_wr.we && mem_wr.addr[7:0] > 8'h03 |-> mem_wr.data == $past(rx_in.data); endproperty
    property p_stop; acc && paddr == rrtd_pkg::OFS_CMD && pwdata[0] |=> !remote_dma_en; endproperty
    property p_start; acc && paddr == rrtd_pkg::OFS_CMD && pwdata[1:0] == 2'b10 |=> remote_dma_en; endproperty
    property p_loop; acc && paddr == rrtd_pkg::OFS_TXCFG |=> loopback_mode == $past(pwdata[2:1]); endproperty
    property p_word; word_mode |-> $past(host_wide_pin); endproperty
    property p_hold; tx_out.valid && !tx_ready |=> tx_out.valid && $stable(tx_out.data); endproperty
    a_hdr: assert property (p_hdr) else $error("header writes out of order");
    a_gap: assert property (p_gap) else $error("receive pause not four cycles");
    a_store: assert property (p_store) else $error("byte stored without cause");
    a_data: assert property (p_data) else $error("stored byte differs");
    a_stop: assert property (p_stop) else $error("stop left remote channel on");
    a_start: assert property (p_start) else $error("start left remote channel off");
    a_loop: assert property (p_loop) else $error("loopback field wrong");
    a_word: assert property (p_word) else $error("word mode without wide host");
    a_hold: assert property (p_hold) else $error("transmit byte dropped");
endmodule // rrtd_dma_chk

bind rrtd_dma rrtd_dma_chk #(.STOP_WAIT_CYC(STOP_WAIT_CYC)) rrtd_dma_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_in(rx_in),
    .rx_ready(rx_ready), .mem_wr(mem_wr), .tx_out(tx_out), .tx_ready(tx_ready), .host_wide_pin(host_wide_pin),
    .word_mode(word_mode), .loopback_mode(loopback_mode), .remote_dma_en(remote_dma_en));

`default_nettype wire

// file: tb/rrtd_far_model.sv
/*
 Far side model: byte-wide buffer memory and a transmit FIFO sink that stalls at random.
 Assumes the bench seeds $urandom before the first clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module rrtd_far_model (
    input wire logic pclk,
    input wire rrtd_pkg::rrtd_mem_wr_t mem_wr,
    input wire logic mem_rd_en,
    input wire logic [15:0] mem_rd_addr,
    output logic [7:0] mem_rd_data,
    input wire rrtd_pkg::rrtd_tx_t tx_out,
    output logic tx_ready
);
    logic [7:0] mem [0:65535];
    logic [7:0] txq [$];
    initial begin
        mem_rd_data = 8'h00;
        tx_ready = 1'b0;
    end
    always @(posedge pclk) begin
        if (mem_wr.we) begin
            mem[mem_wr.addr] <= mem_wr.data;
        end
        // Idle read data flips so a late sample never looks valid
        mem_rd_data <= mem_rd_en ? mem[mem_rd_addr] : ~mem_rd_data;
        if (tx_out.valid && tx_ready) begin
            txq.push_back(tx_out.data);
        end
        tx_ready <= ($urandom % 4) != 0;
    end
endmodule // rrtd_far_model

`default_nettype wire

// file: tb/rrtd_dma_bench.sv
/*
 Self-checking bench for rrtd_dma: ring linking, reject, wrap, overflow recovery, transmit.
 Assumes the far side model and a bound checker.
*/
`timescale 1ns/100ps
`default_nettype none

module rrtd_dma_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_ready, mem_rd_en, tx_ready;
    logic tx_error, host_wide_pin, word_mode, remote_dma_en, rerr, transmit_pending_bit, resend;
    logic [7:0] paddr, mem_rd_data, fb, lb, keep;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] mem_rd_addr;
    logic [1:0] loopback_mode;
    logic [7:0] txd [64];
    rrtd_pkg::rrtd_rx_t rx_in;
    rrtd_pkg::rrtd_mem_wr_t mem_wr;
    rrtd_pkg::rrtd_tx_t tx_out;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    rrtd_dma #(.STOP_WAIT_CYC(20)) rrtd_dma_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .rx_ready(rx_ready), .mem_wr(mem_wr), .mem_rd_en(mem_rd_en),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .tx_out(tx_out), .tx_ready(tx_ready),
        .tx_error(tx_error), .host_wide_pin(host_wide_pin), .word_mode(word_mode),
        .loopback_mode(loopback_mode), .remote_dma_en(remote_dma_en));
    rrtd_far_model rrtd_far_model_inst (.pclk(pclk), .mem_wr(mem_wr), .mem_rd_en(mem_rd_en),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .tx_out(tx_out), .tx_ready(tx_ready));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("BAD %0t hang", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, exp);
    endtask

    // Bad bit 0 flags a CRC error, bit 1 an alignment error
    task automatic rx(input int n, input logic [1:0] bad);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (i == 0) fb = b;
            lb = b;
            rx_in <= '{1'b1, b, i == n - 1, bad[0], bad[1]};
            do @(negedge pclk); while (rx_ready !== 1'b1);
            @(posedge pclk);
        end
        rx_in.valid <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        void'($urandom(34));
        {psel, penable, pwrite, paddr, pwdata, tx_error, host_wide_pin} = '0;
        rx_in = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(rrtd_pkg::OFS_CMD, 32'hFF, 32'h01);
        apb(1'b1, rrtd_pkg::OFS_RING_PAGE_START, 32'h01);
        apb(1'b1, rrtd_pkg::OFS_PEND, 32'h04);
        apb(1'b1, rrtd_pkg::OFS_CURPG, 32'h01);
        apb(1'b1, rrtd_pkg::OFS_CMD, 32'(rrtd_pkg::CMD_START_VAL));
        rdchk(rrtd_pkg::OFS_CMD, 32'hFF, 32'h22);
        rx(300, 2'b00);
        keep = lb;
        chk(rrtd_far_model_inst.mem[16'h0104], fb);
        chk(rrtd_far_model_inst.mem[16'h022F], lb);
        chk(rrtd_far_model_inst.mem[16'h0101], 32'h03);
        chk(rrtd_far_model_inst.mem[16'h0102], 32'h2C);
        chk(rrtd_far_model_inst.mem[16'h0103], 32'h01);
        rdchk(rrtd_pkg::OFS_CURPG, 32'hFF, 32'h03);
        rdchk(rrtd_pkg::OFS_ISTAT, 32'h1F, 32'h01);
        $display("long frame done");
        for (int e = 0; e < 3; e++) rx(e == 0 ? 40 : 70, 2'(e));
        rdchk(rrtd_pkg::OFS_CURPG, 32'hFF, 32'h03);
        rdchk(rrtd_pkg::OFS_ISTAT, 32'h1F, 32'h05);
        apb(1'b1, rrtd_pkg::OFS_CFG, 32'h02);
        rx(40, 2'b00);
        chk(rrtd_far_model_inst.mem[16'h0301], 32'h01);
        rdchk(rrtd_pkg::OFS_CURPG, 32'hFF, 32'h01);
        $display("reject and wrap done");
        apb(1'b1, rrtd_pkg::OFS_BNDRY, 32'h02);
        rx(300, 2'b00);
        rdchk(rrtd_pkg::OFS_ISTAT, 32'h10, 32'h10);
        rdchk(rrtd_pkg::OFS_CURPG, 32'hFF, 32'h01);
        chk(rrtd_far_model_inst.mem[16'h022F], keep);
        apb(1'b0, rrtd_pkg::OFS_CMD, 32'h0);
        transmit_pending_bit = rdat[rrtd_pkg::CMD_TXP_BIT];
        apb(1'b1, rrtd_pkg::OFS_CMD, 32'(rrtd_pkg::CMD_STOP_VAL));
        repeat (30) @(posedge pclk);
        chk(remote_dma_en, 32'h0);
        apb(1'b1, rrtd_pkg::OFS_RMCNT, 32'h0);
        rdchk(rrtd_pkg::OFS_RMCNT, 32'hFFFF, 32'h0);
        apb(1'b0, rrtd_pkg::OFS_ISTAT, 32'h0);
        resend = transmit_pending_bit && !rdat[rrtd_pkg::IS_PTX_BIT] && !rdat[rrtd_pkg::IS_TXE_BIT];
        apb(1'b1, rrtd_pkg::OFS_TXCFG, 32'h02);
        apb(1'b1, rrtd_pkg::OFS_CMD, 32'(rrtd_pkg::CMD_START_VAL));
        @(posedge pclk);
        chk(loopback_mode, 32'h1);
        chk(remote_dma_en, 32'h1);
        apb(1'b1, rrtd_pkg::OFS_BNDRY, 32'h00);
        apb(1'b1, rrtd_pkg::OFS_ISTAT, 32'h10);
        apb(1'b1, rrtd_pkg::OFS_TXCFG, 32'h0);
        rdchk(rrtd_pkg::OFS_ISTAT, 32'h10, 32'h0);
        if (resend) apb(1'b1, rrtd_pkg::OFS_CMD, 32'(rrtd_pkg::CMD_XMIT_VAL));
        $display("overflow recovery done");
        foreach (txd[i]) begin
            txd[i] = 8'($urandom);
            rrtd_far_model_inst.mem[{8'h05, 8'(i)}] = txd[i];
        end
        apb(1'b1, rrtd_pkg::OFS_TXPG, 32'h05);
        apb(1'b1, rrtd_pkg::OFS_TXCNT, 32'd64);
        apb(1'b1, rrtd_pkg::OFS_CMD, 32'(rrtd_pkg::CMD_XMIT_VAL));
        for (int k = 0; k < 2000 && rrtd_far_model_inst.txq.size() < 64; k++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(rrtd_far_model_inst.txq.size(), 32'd64);
        foreach (txd[i]) chk(rrtd_far_model_inst.txq[i], txd[i]);
        rdchk(rrtd_pkg::OFS_ISTAT, 32'h02, 32'h02);
        $display("transmit done");
        apb(1'b1, rrtd_pkg::OFS_CFG, 32'h01);
        for (int w = 0; w < 2; w++) begin
            host_wide_pin <= w[0];
            repeat (3) @(posedge pclk);
            chk(word_mode, 32'(w));
        end
        apb(1'b0, 8'h3C, 32'h0);
        chk(rdat, 32'h0);
        chk(rerr, 32'h1);
        $display("width and unmapped done");
        finish_test();
    end
endmodule // rrtd_dma_bench

`default_nettype wire
